/* File: rtl/tarc_defines.svh */
`ifndef TARC_DEFINES_SVH
`define TARC_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TARC_ADDR_LIMIT   8'h00
`define TARC_ADDR_WAIT    8'h04
`define TARC_ADDR_COUNT   8'h08
`define TARC_ADDR_CLASS   8'h0C
`define TARC_ADDR_STATUS  8'h10
`define TARC_ADDR_MASK    8'h14
`define TARC_ADDR_STATE   8'h18

// ----------------------------------------
// Reset values and special settings
// ----------------------------------------
`define TARC_LIMIT_RESET  8'h00
`define TARC_LIMIT_MAX    8'h0A
`define TARC_WAIT_RESET   16'h270F
`define TARC_WAIT_INHIBIT 16'h270F
`define TARC_CLASS_RESET  8'h00
`define TARC_COUNT_RESET  16'h0000
`define TARC_SUCCESS_MULT 19'h00005

// ----------------------------------------
// Interrupt status bit positions
// ----------------------------------------
`define TARC_IRQ_W        4
`define TARC_IRQ_TRIP     0
`define TARC_IRQ_RESTART  1
`define TARC_IRQ_SUCCESS  2
`define TARC_IRQ_LOCKOUT  3

// ----------------------------------------
// Timing
// ----------------------------------------
`define TARC_WAIT_UNIT_MS  100
`define TARC_CLK_PERIOD_NS 50
`define TARC_TICK_CYCLES  ((`TARC_WAIT_UNIT_MS * 1000000) / `TARC_CLK_PERIOD_NS)

`endif

/* File: rtl/tarc_pkg.sv */
package tarc_pkg;

  // ----------------------------------------
  // Retry sequencer states, Gray along run-wait-confirm
  // ----------------------------------------
  typedef enum logic [1:0] {
    TARC_ST_RUN     = 2'b00,
    TARC_ST_WAIT    = 2'b01,
    TARC_ST_CONFIRM = 2'b11,
    TARC_ST_LOCK    = 2'b10
  } tarc_state_t;

  // ----------------------------------------
  // Fault class flags of one trip
  // ----------------------------------------
  typedef struct packed {
    logic other_alarm;
    logic parameter_storage_alarm;
    logic stall_overload_trip;
    logic ground_fault_trip;
    logic brake_transistor_alarm;
    logic undervoltage_trip;
    logic momentary_power_loss_trip;
    logic overvoltage_trip;
    logic overcurrent_trip;
  } tarc_fault_t;

  // ----------------------------------------
  // Commands toward the drive sequencer
  // ----------------------------------------
  typedef struct packed {
    logic shutoff;
    logic trip_clear;
    logic restart;
    logic thermal_clear;
  } tarc_drive_t;

endpackage : tarc_pkg

/* File: rtl/tarc_tick_gen.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Wait-time unit prescaler
// ----------------------------------------
module tarc_tick_gen #(
  parameter int unsigned CYCLES = 2000000
) (
  // Clock and reset
  input  logic pclk,
  input  logic presetn,
  input  logic ce,
  // Control and tick
  input  logic restart,
  output logic tick
);

  localparam int unsigned W = $clog2(CYCLES) + 1;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Restart zeroes the phase so waits count from the trip itself
  always_comb begin
    cnt_d = cnt_q;
    tick  = 1'b0;
    if (restart) begin
      cnt_d = '0;
    end else if (cnt_q == W'(CYCLES - 1)) begin
      cnt_d = '0;
      tick  = 1'b1;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : tarc_tick_gen

/* File: rtl/tarc_ctrl.sv */
`timescale 1ns/1ps
`include "tarc_defines.svh"

// Behaviour
// - Limit 0 disables retry; 1 to 10 allows at most that many restarts.
// - After an eligible trip wait the set time from the trip, then clear and restart.
// - Wait setting 9999, the reset default, suppresses every retry.
// - Software can read the cumulative count of successful retry restarts.
// - Writing 0 to the success count clears it.
// - Class 0 any alarm, 1 overcurrent, 2 overvoltage, 3 either of the two.
// - Class 4 retries only the eight listed protective alarms.
// - Count rises by 1 after five wait times of alarm-free running.
// - Retry trip reset keeps thermal and brake duty data; only external reset clears.
module tarc_ctrl #(
  parameter int unsigned TICK_CYCLES = `TARC_TICK_CYCLES
) (
  // Clock and reset
  input  logic                 pclk,
  input  logic                 presetn,
  input  logic                 ce,
  // APB slave
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [7:0]           paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Drive side
  input  logic                 trip_event,
  input  tarc_pkg::tarc_fault_t fault,
  input  logic                 ext_reset,
  output tarc_pkg::tarc_drive_t drive,
  // Interrupt
  output logic                 irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]               limit_q,  limit_d;
  logic [15:0]              wait_q,   wait_d;
  logic [15:0]              count_q,  count_d;
  logic [7:0]               class_q,  class_d;
  logic [`TARC_IRQ_W-1:0]   stat_q,   stat_d;
  logic [`TARC_IRQ_W-1:0]   mask_q,   mask_d;
  logic [31:0]              prdata_q, prdata_d;
  tarc_pkg::tarc_state_t    state_q,  state_d;
  logic [18:0]              ticks_q,  ticks_d;
  logic [7:0]               used_q,   used_d;
  tarc_pkg::tarc_drive_t    drive_q,  drive_d;
  logic [`TARC_IRQ_W-1:0]   ev;
  logic                     setup;
  logic                     wr;
  logic                     rd;
  logic                     addr_ok;
  logic                     eligible;
  logic                     can_retry;
  logic                     success;
  logic                     tb_restart;
  logic                     tick;
  logic [18:0]              confirm_lim;
  logic [31:0]              rd_val;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  tarc_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (tb_restart),
    .tick    (tick)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Zero wait states; a low clock enable stretches the access instead
  assign pready  = ce;
  assign setup   = psel & ~penable & ce;
  assign wr      = psel & penable & pwrite & ce;
  assign rd      = psel & penable & ~pwrite & ce;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_q;

  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 32'h00000000;
    case (paddr)
      `TARC_ADDR_LIMIT:  rd_val = {24'h000000, limit_q};
      `TARC_ADDR_WAIT:   rd_val = {16'h0000, wait_q};
      `TARC_ADDR_COUNT:  rd_val = {16'h0000, count_q};
      `TARC_ADDR_CLASS:  rd_val = {24'h000000, class_q};
      `TARC_ADDR_STATUS: rd_val = {28'h0000000, stat_q};
      `TARC_ADDR_MASK:   rd_val = {28'h0000000, mask_q};
      `TARC_ADDR_STATE:  rd_val = {22'h0, used_q, state_q};
      default:           addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Fault class eligibility
  // ----------------------------------------
  always_comb begin
    case (class_q)
      8'h00:   eligible = |fault;
      8'h01:   eligible = fault.overcurrent_trip;
      8'h02:   eligible = fault.overvoltage_trip;
      8'h03:   eligible = fault.overcurrent_trip | fault.overvoltage_trip;
      8'h04:   eligible = fault.overcurrent_trip | fault.overvoltage_trip
                        | fault.momentary_power_loss_trip | fault.undervoltage_trip
                        | fault.brake_transistor_alarm | fault.ground_fault_trip
                        | fault.stall_overload_trip
                        | fault.parameter_storage_alarm;
      default: eligible = 1'b0;
    endcase
  end

  // A limit of zero leaves no budget at all
  assign can_retry = eligible && (wait_q != `TARC_WAIT_INHIBIT)
                     && (used_q < limit_q);
  assign confirm_lim = {3'h0, wait_q} * `TARC_SUCCESS_MULT;

  // ----------------------------------------
  // Retry sequencer
  // ----------------------------------------
  always_comb begin
    state_d    = state_q;
    ticks_d    = ticks_q;
    used_d     = used_q;
    drive_d    = '0;
    ev         = '0;
    success    = 1'b0;
    tb_restart = 1'b0;
    if (ext_reset) begin
      // External reset is the only way out of lockout and clears thermal data
      state_d               = tarc_pkg::TARC_ST_RUN;
      ticks_d               = '0;
      used_d                = '0;
      drive_d.trip_clear    = 1'b1;
      drive_d.thermal_clear = 1'b1;
    end else begin
      case (state_q)
        tarc_pkg::TARC_ST_RUN, tarc_pkg::TARC_ST_CONFIRM: begin
          if (trip_event) begin
            ev[`TARC_IRQ_TRIP] = 1'b1;
            if (can_retry) begin
              state_d    = tarc_pkg::TARC_ST_WAIT;
              used_d     = used_q + 8'h01;
              ticks_d    = '0;
              tb_restart = 1'b1;
            end else begin
              state_d                = tarc_pkg::TARC_ST_LOCK;
              ev[`TARC_IRQ_LOCKOUT]  = 1'b1;
            end
          end else if (state_q == tarc_pkg::TARC_ST_CONFIRM) begin
            if (ticks_q == confirm_lim) begin
              state_d               = tarc_pkg::TARC_ST_RUN;
              success               = 1'b1;
              used_d                = '0;
              ticks_d               = '0;
              ev[`TARC_IRQ_SUCCESS] = 1'b1;
            end else if (tick) begin
              ticks_d = ticks_q + 19'h00001;
            end
          end
        end
        tarc_pkg::TARC_ST_WAIT: begin
          if (ticks_q == {3'h0, wait_q}) begin
            // Trip reset only; accumulated thermal data stays intact
            state_d               = tarc_pkg::TARC_ST_CONFIRM;
            drive_d.trip_clear    = 1'b1;
            drive_d.restart       = 1'b1;
            drive_d.thermal_clear = 1'b0;
            ticks_d               = '0;
            tb_restart            = 1'b1;
            ev[`TARC_IRQ_RESTART] = 1'b1;
          end else if (tick) begin
            ticks_d = ticks_q + 19'h00001;
          end
        end
        tarc_pkg::TARC_ST_LOCK: begin
          state_d = tarc_pkg::TARC_ST_LOCK;
        end
        default: begin
          state_d = tarc_pkg::TARC_ST_RUN;
        end
      endcase
    end
    drive_d.shutoff = (state_d == tarc_pkg::TARC_ST_WAIT)
                    || (state_d == tarc_pkg::TARC_ST_LOCK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tarc_pkg::TARC_ST_RUN;
      ticks_q <= '0;
      used_q  <= '0;
      drive_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      ticks_q <= ticks_d;
      used_q  <= used_d;
      drive_q <= drive_d;
    end
  end

  assign drive = drive_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_comb begin
    limit_d  = limit_q;
    wait_d   = wait_q;
    class_d  = class_q;
    mask_d   = mask_q;
    count_d  = count_q;
    stat_d   = stat_q;
    prdata_d = prdata_q;
    if (wr) begin
      case (paddr)
        // Settings above ten saturate so the budget never exceeds ten
        `TARC_ADDR_LIMIT: limit_d = (pwdata[7:0] > `TARC_LIMIT_MAX) ?
                                    `TARC_LIMIT_MAX : pwdata[7:0];
        `TARC_ADDR_WAIT:  wait_d  = pwdata[15:0];
        `TARC_ADDR_CLASS: class_d = pwdata[7:0];
        `TARC_ADDR_MASK:  mask_d  = pwdata[`TARC_IRQ_W-1:0];
        `TARC_ADDR_COUNT: begin
          if (pwdata == 32'h00000000) begin
            count_d = 16'h0000;
          end
        end
        default: ;
      endcase
    end
    // Increment lands after the clear so a coincident success is kept
    if (success) begin
      count_d = count_d + 16'h0001;
    end
    if (rd && (paddr == `TARC_ADDR_STATUS)) begin
      stat_d = '0;
    end
    stat_d = stat_d | ev;
    if (setup) begin
      prdata_d = rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q  <= `TARC_LIMIT_RESET;
      wait_q   <= `TARC_WAIT_RESET;
      class_q  <= `TARC_CLASS_RESET;
      mask_q   <= '0;
      count_q  <= `TARC_COUNT_RESET;
      stat_q   <= '0;
      prdata_q <= 32'h00000000;
    end else if (ce) begin
      limit_q  <= limit_d;
      wait_q   <= wait_d;
      class_q  <= class_d;
      mask_q   <= mask_d;
      count_q  <= count_d;
      stat_q   <= stat_d;
      prdata_q <= prdata_d;
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_idle_trip;
    ce && !ext_reset && trip_event && (state_q == tarc_pkg::TARC_ST_RUN);
  endsequence

  sequence s_wait_done;
    ce && !ext_reset && (state_q == tarc_pkg::TARC_ST_WAIT)
    && (ticks_q == {3'h0, wait_q});
  endsequence

  a_zero_limit_lock: assert property (
    s_idle_trip ##0 (limit_q == 8'h00) |=> (state_q == tarc_pkg::TARC_ST_LOCK))
    else $error("zero retry limit did not lock out");

  a_budget_bound: assert property (
    used_q <= limit_q || $past(wr && paddr == `TARC_ADDR_LIMIT))
    else $error("retry attempts exceed limit");

  a_wait_restart: assert property (
    s_wait_done |=> drive.restart && drive.trip_clear && drive.shutoff == 1'b0)
    else $error("restart not issued after wait time");

  a_restart_cause: assert property (
    $rose(drive.restart) |-> $past(state_q) == tarc_pkg::TARC_ST_WAIT)
    else $error("restart without preceding wait");

  a_inhibit_lock: assert property (
    s_idle_trip ##0 (wait_q == `TARC_WAIT_INHIBIT) |=> drive.shutoff
      ##0 (state_q == tarc_pkg::TARC_ST_LOCK))
    else $error("retry made with inhibit wait setting");

  a_count_read: assert property (
    (setup && paddr == `TARC_ADDR_COUNT) |=> prdata == {16'h0000, $past(count_q)})
    else $error("success count read mismatch");

  a_count_clear: assert property (
    (wr && paddr == `TARC_ADDR_COUNT && pwdata == 32'h00000000 && !success)
      |=> count_q == 16'h0000)
    else $error("count not cleared by zero write");

  a_class_oc_only: assert property (
    s_idle_trip ##0 (class_q == 8'h01) && !fault.overcurrent_trip
      |=> state_q == tarc_pkg::TARC_ST_LOCK)
    else $error("class 1 retried a non overcurrent trip");

  a_class4_other: assert property (
    s_idle_trip ##0 (class_q == 8'h04) && (fault == 9'h100)
      |=> state_q == tarc_pkg::TARC_ST_LOCK)
    else $error("class 4 retried an unlisted alarm");

  a_success_inc: assert property (
    (ce && success && !(wr && paddr == `TARC_ADDR_COUNT))
      |=> count_q == $past(count_q) + 16'h0001 ##0 state_q == tarc_pkg::TARC_ST_RUN)
    else $error("success count not incremented");

  a_keep_thermal: assert property (
    drive.restart |-> !drive.thermal_clear)
    else $error("retry reset cleared thermal data");

  a_lock_holds: assert property (
    (state_q == tarc_pkg::TARC_ST_LOCK) && !ext_reset
      |=> (state_q == tarc_pkg::TARC_ST_LOCK) && drive.shutoff)
    else $error("lockout released without external reset");

  a_budget_refill: assert property (
    (ce && success) |=> used_q == 8'h00)
    else $error("attempt budget not restored");

endmodule : tarc_ctrl

/* File: verif/tarc_drive_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Drive side: trip detectors and sequencer watch
// ----------------------------------------
module tarc_drive_model (
  // Clock and reset
  input  logic                  pclk,
  input  logic                  presetn,
  // Toward the controller
  output logic                  trip_event,
  output tarc_pkg::tarc_fault_t fault,
  input  tarc_pkg::tarc_drive_t drive
);
  int restarts;
  int thermal_clears;
  int since_trip;
  int last_delay;

  initial begin
    trip_event = 1'b0;
    fault      = '0;
  end

  // Flags mean nothing outside the pulse, so show their inverse afterwards
  task automatic fire(input tarc_pkg::tarc_fault_t f);
    @(posedge pclk);
    trip_event <= 1'b1;
    fault      <= f;
    @(posedge pclk);
    trip_event <= 1'b0;
    fault      <= ~f;
  endtask : fire

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restarts       <= 0;
      thermal_clears <= 0;
      since_trip     <= 0;
      last_delay     <= 0;
    end else begin
      since_trip <= trip_event ? 1 : since_trip + 1;
      if (drive.restart) begin
        restarts   <= restarts + 1;
        last_delay <= since_trip;
      end
      if (drive.thermal_clear) begin
        thermal_clears <= thermal_clears + 1;
      end
    end
  end
endmodule : tarc_drive_model

/* File: verif/tb_trip_auto_retry_controller.sv */
`timescale 1ns/1ps
`include "tarc_defines.svh"
module tb_trip_auto_retry_controller;
  localparam int unsigned TICK = 4;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} tarc_note_t;

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce = 1'b1, ext_reset = 1'b0, pready, pslverr, irq, trip_event;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata;
  tarc_pkg::tarc_fault_t fault;
  tarc_pkg::tarc_drive_t drive;
  tarc_note_t            notes[$];
  tarc_note_t            n;
  int num_errors = 0, comparisons = 0, tc;

  always #25 pclk = ~pclk;

  tarc_ctrl #(.TICK_CYCLES(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trip_event(trip_event),
    .fault(fault), .ext_reset(ext_reset), .drive(drive), .irq(irq));
  tarc_drive_model u_model (.pclk(pclk), .presetn(presetn), .trip_event(trip_event),
    .fault(fault), .drive(drive));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Master holds every signal until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic e = 1'b0);
    notes.push_back('{d, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic xrst;
    @(posedge pclk);
    ext_reset <= 1'b1;
    @(posedge pclk);
    ext_reset <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : xrst

  task automatic wait_restart;
    int k;
    k = 0;
    while (drive.restart !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    check("restart seen", 32'(k < 200), 32'h1);
    check("trip clear", 32'(drive.trip_clear), 32'h1);
  endtask : wait_restart

  function automatic logic elig(input int c, input int b);
    case (c)
      0: return 1'b1;
      1: return b == 0;
      2: return b == 1;
      3: return b < 2;
      4: return b < 8;
      default: return 1'b0;
    endcase
  endfunction : elig

  // Read data checked in arrival order against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      n = notes.pop_front();
      check("read data", prdata & n.m, n.d);
      check("slave error", 32'(pslverr), 32'(n.e));
    end
  end

  initial begin
    #(50 * 30000);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h240E));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TARC_ADDR_LIMIT, 32'h0);
    rd(`TARC_ADDR_WAIT, 32'h270F);
    rd(`TARC_ADDR_COUNT, 32'h0);
    rd(`TARC_ADDR_CLASS, 32'h0);
    rd(`TARC_ADDR_STATE, 32'h0);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, `TARC_ADDR_LIMIT, 32'hFF);
    rd(`TARC_ADDR_LIMIT, 32'h0A);
    u_model.fire(9'h001);
    rd(`TARC_ADDR_STATE, 32'h2, 32'h3);
    check("shutoff latched", 32'(drive.shutoff), 32'h1);
    xrst();
    apb(1'b1, `TARC_ADDR_LIMIT, 32'h0);
    apb(1'b1, `TARC_ADDR_WAIT, 32'h0);
    u_model.fire(9'h001);
    rd(`TARC_ADDR_STATE, 32'h2, 32'h3);
    xrst();
    apb(1'b1, `TARC_ADDR_LIMIT, 32'h0A);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `TARC_ADDR_CLASS, 32'(c));
      apb(1'b1, `TARC_ADDR_WAIT, 32'(1 + $urandom_range(2)));
      for (int b = 0; b < 9; b++) begin
        u_model.fire(tarc_pkg::tarc_fault_t'(9'h001 << b));
        rd(`TARC_ADDR_STATE, elig(c, b) ? 32'h1 : 32'h2, 32'h3);
        xrst();
      end
    end
    rd(`TARC_ADDR_STATUS, 32'h9);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b1, `TARC_ADDR_MASK, 32'hF);
    apb(1'b1, `TARC_ADDR_CLASS, 32'h0);
    apb(1'b1, `TARC_ADDR_LIMIT, 32'h2);
    apb(1'b1, `TARC_ADDR_WAIT, 32'h1);
    tc = u_model.thermal_clears;
    u_model.fire(9'h100);
    wait_restart();
    @(posedge pclk);
    check("wait span", 32'(u_model.last_delay >= TICK && u_model.last_delay <= TICK + 4),
          32'h1);
    rd(`TARC_ADDR_COUNT, 32'h0);
    repeat (5 * TICK + 10) @(posedge pclk);
    rd(`TARC_ADDR_COUNT, 32'h1);
    rd(`TARC_ADDR_STATE, 32'h0, 32'h3);
    u_model.fire(9'h002);
    wait_restart();
    @(posedge pclk);
    u_model.fire(9'h002);
    wait_restart();
    @(posedge pclk);
    u_model.fire(9'h002);
    rd(`TARC_ADDR_STATE, 32'h2, 32'h3);
    check("thermal data kept", 32'(u_model.thermal_clears - tc), 32'h0);
    check("irq raised", 32'(irq), 32'h1);
    rd(`TARC_ADDR_STATUS, 32'hF);
    @(posedge pclk);
    check("irq cleared", 32'(irq), 32'h0);
    rd(`TARC_ADDR_COUNT, 32'h1);
    apb(1'b1, `TARC_ADDR_COUNT, 32'h5);
    rd(`TARC_ADDR_COUNT, 32'h1);
    apb(1'b1, `TARC_ADDR_COUNT, 32'h0);
    rd(`TARC_ADDR_COUNT, 32'h0);
    // Clock enable drops in the access phase: pready must stall the read
    fork
      rd(`TARC_ADDR_STATE, 32'h2, 32'h3);
      begin
        repeat (2) @(posedge pclk);
        ce <= 1'b0;
        @(posedge pclk);
        check("pready held low", 32'(pready), 32'h0);
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    check("shutoff frozen", 32'(drive.shutoff), 32'h1);
    repeat (3) @(posedge pclk);
    check("notes drained", 32'(notes.size()), 32'h0);
    tally_and_finish();
  end
endmodule : tb_trip_auto_retry_controller
